// ===== verilog/nvc_pkg.sv
`default_nettype none
package nvc_pkg;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 15;          // byte address width
  localparam int DATA_W    = 8;           // byte width
  localparam int KEY_BITS  = 64;          // key length and transfer length
  localparam int STEP_W    = 7;           // step counter width
  localparam logic [STEP_W-1:0] LAST_STEP = 7'h3f; // 64th step index

  // key bytes c5 3a a3 5c twice, byte 0 in the low bits, lsb sent first
  localparam logic [63:0] KEY_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;

  // scratch byte used by the opening read and the key writes
  localparam logic [ADDR_W-1:0] SCRATCH_ADDR = 15'h7fff;

  // ----------------------------------------------------------------
  // timing, slowest grade, 100 mhz clock
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 10;          // clock period in ns
  localparam int RD_CYC_NS = 200;         // read cycle time, covers access
  localparam int WR_PW_NS  = 200;         // write cycle time used as pulse
  localparam int WR_REC_NS = 20;          // write_recovery_time
  localparam int RD_CYC    = (RD_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC    = (WR_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC   = (WR_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W     = 5;           // timer width

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // user operations
  typedef enum logic [1:0] {
    OP_MEM_RD = 2'h0,
    OP_MEM_WR = 2'h1,
    OP_CLK_RD = 2'h2,
    OP_CLK_WR = 2'h3
  } nvc_op_t;

  // one user request
  typedef struct packed {
    nvc_op_t             op;      // operation
    logic [ADDR_W-1:0]   addr;    // byte address, memory ops only
    logic [DATA_W-1:0]   wdata;   // byte to write, memory write only
    logic [KEY_BITS-1:0] cwdata;  // clock image to write, clock write only
  } nvc_cmd_t;

  // pins driven toward the device
  typedef struct packed {
    logic              chip_sel_n;     // active low chip select
    logic              out_drive_n;    // active low output drive
    logic              write_strobe_n; // active low write strobe
    logic [ADDR_W-1:0] byte_address_lines; // bit 14 is top_address_or_abort
    logic [DATA_W-1:0] dq_o;           // data toward device
    logic              dq_oe;          // high while the host drives data
  } nvc_pins_t;
endpackage : nvc_pkg
`default_nettype wire

// ===== verilog/nvc_host.sv
`default_nettype none
// How it works
// [RL1] read when select low, strobe high
// [RL2] fifteen address lines, eight data bits
// [RL3] sample data only with select and drive
// [RL4] write spans select and strobe both low
// [RL5] address held stable through every write
// [RL6] strobe high recovery before next cycle
// [RL7] output drive kept high during writes
// [RL8] no cycles while power is bad
// [RL9] device shortens short months itself
// [RL10] 64 matching key writes unlock clock
// [RL11] before unlock all accesses hit memory
// [RL12] next 64 cycles move clock data
// [RL13] opening read resets the key pointer
// [RL14] key bit goes on data bit 0
// [RL15] mismatch stalls device pointer, no retry
// [RL16] no reads issued during the key
// [RL17] key writes go to scratch address
// [RL18] transfer one bit per cycle on bit 0
// [RL19] only own cycles count, none interleaved
// [RL20] transfer all 64 bits, reg0 bit0 first
// [RL21] clock written only as whole bytes
// [RL22] clock image passed through as bcd
// [RL23] key c5 3a a3 5c twice lsb first
// [RL24] abort pin held high during transfer
// [RL25] each clock access sends a fresh key
module nvc_host (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  cmd_valid,
  input  wire nvc_pkg::nvc_cmd_t     cmd,
  output var  logic                  cmd_ready,
  output var  logic                  rsp_valid,
  output var  logic [7:0]            rsp_byte,
  output var  logic [63:0]           rsp_clock,
  input  wire logic                  power_good,
  input  wire logic [7:0]            dq_i,
  output var  nvc_pkg::nvc_pins_t    pins
);
  import nvc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // bus cycle states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_ADDR = 6'b00_0010,
    S_RD   = 6'b00_0100,
    S_WR   = 6'b00_1000,
    S_REC  = 6'b01_0000,
    S_DONE = 6'b10_0000
  } nvc_state_t;

  // phases of one user operation, one-hot
  typedef enum logic [3:0] {
    PH_MEM  = 4'b0001,
    PH_OPEN = 4'b0010,
    PH_KEY  = 4'b0100,
    PH_XFER = 4'b1000
  } nvc_phase_t;

  nvc_state_t            state_r;   // bus cycle state
  nvc_phase_t            phase_r;   // operation phase
  nvc_op_t               op_r;      // accepted operation
  logic [ADDR_W-1:0]     addr_r;    // accepted memory address
  logic [DATA_W-1:0]     wdata_r;   // accepted memory byte
  logic [KEY_BITS-1:0]   shift_r;   // clock image shifter
  logic [STEP_W-1:0]     step_r;    // key or transfer bit index
  logic [TMR_W-1:0]      tmr_r;     // cycle timer
  logic                  cyc_wr;    // current access is a write

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // direction of the access made in a given phase
  function automatic logic phase_is_write(input nvc_phase_t ph, input nvc_op_t op);
    case (ph)
      PH_MEM:  phase_is_write = (op == OP_MEM_WR);
      PH_OPEN: phase_is_write = 1'b0;              // RL13
      PH_KEY:  phase_is_write = 1'b1;              // RL16
      PH_XFER: phase_is_write = (op == OP_CLK_WR); // RL18
      default: phase_is_write = 1'b0;
    endcase
  endfunction : phase_is_write

  // timer load value
  function automatic logic [TMR_W-1:0] cyc_len(input int n);
    cyc_len = TMR_W'(n - 1);
  endfunction : cyc_len

  always_comb begin
    cyc_wr = phase_is_write(phase_r, op_r);
  end

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  // one access: address setup, strobe, recovery, then next step
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      tmr_r   <= '0;
    end else begin
      case (state_r)
        // wait for a request, only with good power
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            state_r <= S_ADDR;
          end
        end
        // address and data load at the edge leaving this state, the strobes with them only while power is good
        S_ADDR: begin
          if (!power_good) begin
            state_r <= S_DONE; // RL8
          end else if (cyc_wr) begin
            state_r <= S_WR;
            tmr_r   <= cyc_len(WR_CYC);
          end else begin
            state_r <= S_RD;
            tmr_r   <= cyc_len(RD_CYC);
          end
        end
        // select and drive low for the read cycle
        S_RD: begin
          if (tmr_r == '0) begin
            state_r <= S_REC;
            tmr_r   <= cyc_len(REC_CYC);
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        // select and strobe low for the write pulse
        S_WR: begin
          if (tmr_r == '0) begin
            state_r <= S_REC;
            tmr_r   <= cyc_len(REC_CYC);
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        // strobes high before anything else
        S_REC: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1; // RL6
          end else if (phase_r == PH_MEM ||
                       (phase_r == PH_XFER && step_r == LAST_STEP)) begin
            state_r <= S_DONE; // RL25
          end else begin
            state_r <= S_ADDR;
          end
        end
        // one-cycle answer
        S_DONE: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // operation phases and data
  // ----------------------------------------------------------------
  // steps through open read, 64 key writes, 64 transfer cycles
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= PH_MEM;
      op_r    <= OP_MEM_RD;
      addr_r  <= '0;
      wdata_r <= '0;
      shift_r <= '0;
      step_r  <= '0;
    end else begin
      if (state_r == S_IDLE && cmd_valid && cmd_ready) begin
        op_r    <= cmd.op;
        addr_r  <= cmd.addr;
        wdata_r <= cmd.wdata;
        shift_r <= cmd.cwdata; // RL21 RL22
        step_r  <= '0;
        phase_r <= (cmd.op == OP_CLK_RD || cmd.op == OP_CLK_WR) ? PH_OPEN : PH_MEM; // RL25
      end else if (state_r == S_RD && tmr_r == '0 && phase_r == PH_XFER) begin
        shift_r <= {dq_i[0], shift_r[KEY_BITS-1:1]}; // RL18 RL20
      end else if (state_r == S_WR && tmr_r == '0 && phase_r == PH_XFER) begin
        shift_r <= {1'b0, shift_r[KEY_BITS-1:1]}; // RL20
      end else if (state_r == S_REC && tmr_r == '0) begin
        case (phase_r)
          PH_OPEN: begin
            phase_r <= PH_KEY;
            step_r  <= '0;
          end
          PH_KEY: begin
            if (step_r == LAST_STEP) begin
              phase_r <= PH_XFER; // RL10 RL12
              step_r  <= '0;
            end else begin
              step_r <= step_r + 1'b1;
            end
          end
          PH_XFER: begin
            step_r <= step_r + 1'b1;
          end
          default: begin
            step_r <= step_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // device pins
  // ----------------------------------------------------------------
  // all pins from flops; address and data set up in S_ADDR
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins.chip_sel_n         <= 1'b1;
      pins.out_drive_n        <= 1'b1;
      pins.write_strobe_n     <= 1'b1;
      pins.byte_address_lines <= SCRATCH_ADDR;
      pins.dq_o               <= '0;
      pins.dq_oe              <= 1'b0;
    end else begin
      case (state_r)
        S_ADDR: begin
          if (power_good) begin
            pins.chip_sel_n     <= 1'b0; // RL4
            pins.out_drive_n    <= cyc_wr; // RL3 RL7
            pins.write_strobe_n <= !cyc_wr; // RL1
            pins.dq_oe          <= cyc_wr;
          end
          // non-memory phases use the scratch byte, top bit high
          pins.byte_address_lines <= (phase_r == PH_MEM) ? addr_r : SCRATCH_ADDR; // RL2 RL17 RL24
          if (phase_r == PH_KEY) begin
            pins.dq_o <= {7'h00, KEY_PATTERN[step_r[5:0]]}; // RL14 RL23
          end else if (phase_r == PH_XFER) begin
            pins.dq_o <= {7'h00, shift_r[0]}; // RL18
          end else begin
            pins.dq_o <= wdata_r;
          end
        end
        S_RD, S_WR: begin
          if (tmr_r == '0) begin
            pins.chip_sel_n     <= 1'b1;
            pins.out_drive_n    <= 1'b1;
            pins.write_strobe_n <= 1'b1;
          end
        end
        S_REC: begin
          if (tmr_r == '0) begin
            pins.dq_oe <= 1'b0; // RL5
          end
        end
        default: begin
          pins.chip_sel_n     <= 1'b1;
          pins.out_drive_n    <= 1'b1;
          pins.write_strobe_n <= 1'b1;
          pins.dq_oe          <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // user handshake and answers
  // ----------------------------------------------------------------
  // ready only in idle with good power; answer pulse on done
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte  <= '0;
      rsp_clock <= '0;
    end else begin
      cmd_ready <= (state_r == S_IDLE) && !(cmd_valid && cmd_ready) && power_good; // RL8
      rsp_valid <= (state_r == S_DONE);
      if (state_r == S_RD && tmr_r == '0 && phase_r == PH_MEM) begin
        rsp_byte <= dq_i; // RL3
      end
      if (state_r == S_DONE) begin
        rsp_clock <= shift_r;
      end
    end
  end
endmodule : nvc_host
`default_nettype wire

// ===== sim/nvc_host_checker.sv
`default_nettype none
module nvc_host_checker (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               cmd_valid,
  input wire nvc_pkg::nvc_cmd_t  cmd,
  input wire logic               cmd_ready,
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_byte,
  input wire logic [63:0]        rsp_clock,
  input wire logic               power_good,
  input wire logic [7:0]         dq_i,
  input wire nvc_pkg::nvc_pins_t pins
);
  import nvc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  logic              take;    // request taken this edge
  logic              cop_r;   // clock operation in flight
  logic [ADDR_W-1:0] addr_r;  // address of last request
  logic [DATA_W-1:0] data_r;  // byte of last request
  assign take = cmd_valid && cmd_ready;
  // remember what was asked for
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cop_r <= 1'b0;
    end else if (take) begin
      cop_r <= cmd.op[1];
    end else if (rsp_valid) begin
      cop_r <= 1'b0;
    end
  end
  // address and data of the request
  always_ff @(posedge clk) begin
    if (take) begin
      addr_r <= cmd.addr;
      data_r <= cmd.wdata;
    end
  end
  // ----------------------------------------------------------------
  // clock operation length
  // ----------------------------------------------------------------
  localparam logic [11:0] CLK_OP_MIN = 12'hb90; // 2960 cycles, take to answer
  localparam logic [11:0] CLK_OP_MAX = 12'hba0; // 2976 cycles, take to answer
  logic [11:0] len_r;   // cycles since the last take, counted only while a clock op is in flight
  logic        pgok_r;  // power stayed good since the take
  // a counter stands in for a delay range that long
  always_ff @(posedge clk) begin
    if (!nrst) begin
      len_r  <= '0;
      pgok_r <= 1'b0;
    end else if (take) begin
      len_r  <= 12'h001;
      pgok_r <= power_good;
    end else if (cop_r) begin
      len_r  <= len_r + 12'h001;
      pgok_r <= pgok_r && power_good;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_rd;
    !pins.chip_sel_n && !pins.out_drive_n && pins.write_strobe_n && !pins.dq_oe
      && pins.byte_address_lines == addr_r;
  endsequence
  sequence s_wr;
    !pins.chip_sel_n && !pins.write_strobe_n && pins.out_drive_n && pins.dq_oe
      && pins.byte_address_lines == addr_r && pins.dq_o == data_r;
  endsequence
  // an address phase that meets bad power ends early with no strobe
  property p_rd_walk;
    take && cmd.op == OP_MEM_RD && power_good ##1 power_good
      |-> ##5 s_rd[*4] ##[13:19] rsp_valid;
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("read cycle malformed");
  property p_wr_walk;
    take && cmd.op == OP_MEM_WR && power_good ##1 power_good
      |-> ##5 s_wr[*4] ##[13:19] rsp_valid;
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write cycle malformed");
  property p_clk_len;
    cop_r && pgok_r |-> len_r <= CLK_OP_MAX && (!rsp_valid || len_r >= CLK_OP_MIN);
  endproperty
  a_clk_len: assert property (p_clk_len) else $error("clock op length wrong");
  property p_scratch;
    cop_r && !pins.chip_sel_n |-> pins.byte_address_lines == SCRATCH_ADDR;
  endproperty
  a_scratch: assert property (p_scratch) else $error("clock op off scratch");
  property p_addr_hold;
    !pins.write_strobe_n |=> pins.write_strobe_n || $stable(pins.byte_address_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_rec;
    $rose(pins.write_strobe_n) |-> (pins.write_strobe_n && pins.out_drive_n)[*2];
  endproperty
  a_rec: assert property (p_rec) else $error("write recovery short");
  property p_no_oe_wr;
    !pins.write_strobe_n |-> pins.out_drive_n && !pins.chip_sel_n;
  endproperty
  a_no_oe_wr: assert property (p_no_oe_wr) else $error("drive low in write");
  property p_dq_dir;
    !pins.out_drive_n |-> !pins.dq_oe;
  endproperty
  a_dq_dir: assert property (p_dq_dir) else $error("bus contention");
  property p_pg;
    !power_good |=> !cmd_ready;
  endproperty
  a_pg: assert property (p_pg) else $error("ready while power bad");
endmodule : nvc_host_checker
bind nvc_host nvc_host_checker u_chk (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
  .rsp_clock(rsp_clock), .power_good(power_good), .dq_i(dq_i), .pins(pins));
`default_nettype wire

// ===== sim/nvc_dev_model.sv
`default_nettype none
module nvc_dev_model #(
  parameter logic [63:0] CLK_INIT = 64'h0000_0000_0000_0000
) (
  input wire logic               clk,
  input wire logic               power_good,
  input wire nvc_pkg::nvc_pins_t pins,
  output var logic [7:0]         dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  // key bytes, first byte in the low bits
  localparam logic [63:0] KEY = {8'h5c, 8'ha3, 8'h3a, 8'hc5, 8'h5c, 8'ha3, 8'h3a, 8'hc5};
  logic [7:0]  mem [0:32767];          // byte array
  logic [63:0] creg_r = CLK_INIT;      // clock registers, bcd
  nvc_pins_t   prev_r = '1;            // pins one cycle ago
  logic [6:0]  ptr_r  = 7'h00;         // key pointer
  logic        dead_r = 1'b1;          // key attempt spoiled
  logic        open_r = 1'b0;          // transfer unlocked
  logic [5:0]  bit_r  = 6'h00;         // transfer bit index
  logic [7:0]  last_r = 8'h00;         // last driven byte
  logic        rd_on, rd_end, wr_end;
  // ----------------------------------------------------------------
  // cycle detection and bus drive
  // ----------------------------------------------------------------
  assign rd_on = power_good && !pins.chip_sel_n && !pins.out_drive_n && pins.write_strobe_n;
  assign rd_end = !prev_r.chip_sel_n && !prev_r.out_drive_n && prev_r.write_strobe_n
                  && (pins.chip_sel_n || pins.out_drive_n);
  assign wr_end = !prev_r.chip_sel_n && !prev_r.write_strobe_n
                  && (pins.chip_sel_n || pins.write_strobe_n);
  // released bus shows the inverse of the last byte
  assign dq_i = !rd_on ? ~last_r : open_r ? {7'h00, creg_r[bit_r]} : mem[pins.byte_address_lines];
  // ----------------------------------------------------------------
  // key recognition and transfer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    prev_r <= pins;
    if (rd_on) begin
      last_r <= dq_i;
    end
    if (!power_good) begin
      // inputs ignored
    end else if (open_r && !pins.byte_address_lines[ADDR_W-1]) begin
      // abort pin low, abort enable taken as clear: drop transfer, keep registers
      open_r <= 1'b0;
      dead_r <= 1'b1;
      bit_r  <= 6'h00;
    end else if (open_r && (rd_end || wr_end)) begin
      if (wr_end) begin
        creg_r[bit_r] <= prev_r.dq_o[0];
      end
      bit_r <= bit_r + 6'h01;
      if (bit_r == 6'h3f) begin
        open_r <= 1'b0;
        dead_r <= 1'b1;
      end
    end else if (rd_end) begin
      ptr_r  <= 7'h00;
      dead_r <= 1'b0;
    end else if (wr_end) begin
      mem[prev_r.byte_address_lines] <= prev_r.dq_o;
      if (!dead_r && prev_r.dq_o[0] === KEY[ptr_r[5:0]]) begin
        ptr_r <= ptr_r + 7'h01;
        open_r <= (ptr_r == 7'h3f);
      end else begin
        dead_r <= 1'b1;
      end
    end
  end
endmodule : nvc_dev_model
`default_nettype wire

// ===== sim/tb_nvc_host.sv
`default_nettype none
module tb_nvc_host;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  localparam logic [63:0] IMG0 = 64'h2406_1512_3059_4500; // power-up clock image
  localparam logic [63:0] IMG1 = 64'h2512_3104_0659_3017; // image written later
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        power_good = 1'b1;
  nvc_cmd_t    cmd = '0;
  logic        cmd_ready, rsp_valid;
  logic [7:0]  rsp_byte, dq_i;
  logic [63:0] rsp_clock;
  nvc_pins_t   pins;
  int          fails = 0;
  int          check_count = 0;
  // clock at 100 mhz
  initial begin
    forever #5 clk = ~clk;
  end
  nvc_host DUT (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .rsp_clock(rsp_clock), .power_good(power_good), .dq_i(dq_i), .pins(pins));
  nvc_dev_model #(.CLK_INIT(IMG0)) u_dev (.clk(clk), .power_good(power_good),
    .pins(pins), .dq_i(dq_i));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // one request, held until taken; a refusal past the bound is a mismatch
  task automatic issue(input nvc_op_t op, input logic [14:0] a, input logic [7:0] d,
                       input logic [63:0] c);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{op, a, d, c};
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 50) begin
      fails++;
      conclude();
    end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask : issue
  // one request, then wait for the answer
  task automatic run(input nvc_op_t op, input logic [14:0] a, input logic [7:0] d,
                     input logic [63:0] c);
    int n;
    n = 0;
    issue(op, a, d, c);
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 4000) begin
      fails++;
      conclude();
    end
  endtask : run
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_mem;
    run(OP_MEM_WR, 15'h0000, 8'ha5, 64'h0);
    run(OP_MEM_WR, 15'h7ffe, 8'h3c, 64'h0);
    run(OP_MEM_RD, 15'h0000, 8'h00, 64'h0);
    chk("byte", rsp_byte, 8'ha5);
    run(OP_MEM_RD, 15'h7ffe, 8'h00, 64'h0);
    chk("byte", rsp_byte, 8'h3c);
    $display("memory test done");
  endtask : t_mem
  task automatic t_clk;
    run(OP_CLK_RD, 15'h0000, 8'h00, 64'h0);
    chk("image", rsp_clock, IMG0);
    run(OP_CLK_WR, 15'h0000, 8'h00, IMG1);
    chk("image", rsp_clock, 64'h0);
    run(OP_CLK_RD, 15'h0000, 8'h00, 64'h0);
    chk("image", rsp_clock, IMG1);
    run(OP_MEM_RD, 15'h0000, 8'h00, 64'h0);
    chk("byte", rsp_byte, 8'ha5);
    $display("clock test done");
  endtask : t_clk
  task automatic t_pwr;
    int   n;
    logic low_seen;
    n = 0;
    low_seen = 1'b0;
    @(posedge clk);
    #1 power_good = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("ready", cmd_ready, 1'b0);
    power_good = 1'b1;
    // power fails right after the take: early answer, select never low
    issue(OP_MEM_WR, 15'h7ffe, 8'h99, 64'h0);
    power_good = 1'b0;
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
      if (pins.chip_sel_n !== 1'b1) low_seen = 1'b1;
    end
    if (n >= 10) begin
      fails++;
      conclude();
    end
    chk("select", low_seen, 1'b0);
    power_good = 1'b1;
    run(OP_MEM_RD, 15'h7ffe, 8'h00, 64'h0);
    chk("byte", rsp_byte, 8'h3c);
    $display("power test done");
  endtask : t_pwr
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 chk("idle pins", {cmd_ready, rsp_valid, pins.chip_sel_n, pins.out_drive_n,
                         pins.write_strobe_n, pins.dq_oe}, 6'h0e);
    nrst = 1'b1;
    t_mem();
    t_clk();
    t_pwr();
    conclude();
  end
endmodule : tb_nvc_host
`default_nettype wire
